// ---- rtl/wlm_top.sv ----
// Workpiece length measurement unit with APB register slave
// Operation
// - Modes 0-3 start on high, capture rising
// - Modes 0,1: already high at enable captures initial value
// - Modes 0,1 end on low, capture falling
// - Modes 4,5 start on low, capture falling
// - Done bit set after final capture
// - Modes 2,3 finish after rising capture
// - Even modes count up, odd count down
// - Filter starts at edge, stores edge value
// - Early level change discards buffered value
// - Next proper edge rebuffers and restarts filter
// - Clean filter copies rising value
// - Falling edge buffered, copied on expiry
// - Filter is 32-bit increment count
// - Six modes chosen by mode field
`timescale 1ns/100ps
module wlm_top import wlm_pkg::*; #(
  parameter int CW = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [WLM_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic latch_in,
  input wire logic enc_inc,
  output logic irq
);
  if (CW != 32) begin
    $error("wlm_top: filter and counter are 32 bits");
  end
  logic [31:0] ctrl_reg;
  logic [31:0] filt_reg;
  logic [CW-1:0] rise_reg;
  logic [CW-1:0] fall_reg;
  logic [WLM_STAT_W-1:0] stat_reg;
  logic [WLM_STAT_W-1:0] mask_reg;
  wlm_state_e state_reg;
  logic phase_reg;
  logic latch_d_reg;
  logic [CW-1:0] pos;
  logic fbusy;
  logic fexp;
  logic [CW-1:0] fheld;
  logic wr;
  logic rd;
  logic map_hit;
  logic meas_en;
  logic [WLM_MODE_W-1:0] mode;
  logic mode_ok;
  logic low_first;
  logic both;
  logic want_lvl;
  logic f_start;
  logic f_abort;
  logic rise_wr;
  logic fall_wr;
  logic done_set;
  logic conf_set;
  logic [WLM_STAT_W-1:0] ev;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign map_hit = paddr == WLM_CTRL_OFS || paddr == WLM_FILT_OFS || paddr == WLM_RISE_OFS ||
    paddr == WLM_FALL_OFS || paddr == WLM_STAT_OFS || paddr == WLM_MASK_OFS || paddr == WLM_CNT_OFS;
  assign meas_en = ctrl_reg[WLM_CTRL_MEAS_EN] && !ctrl_reg[WLM_CTRL_CMP_EN];
  assign mode = ctrl_reg[WLM_CTRL_MODE_LO +: WLM_MODE_W];
  assign mode_ok = mode <= WLM_MODE_MAX;
  assign low_first = mode[2];
  assign both = mode[2:1] == 2'b00;
  // Level awaited in the current phase
  assign want_lvl = low_first ? 1'b0 : (phase_reg ? 1'b0 : 1'b1);

  wlm_counter #(.CW(CW)) u_cnt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inc(enc_inc),
    .down(mode[0]),
    .pos(pos)
  );

  // Edge of the awaited polarity while waiting and the filter is idle
  always_comb begin
    f_start = 1'b0;
    if (state_reg == WLM_WAIT_EDGE && meas_en && !fbusy) begin
      if (latch_in == want_lvl && latch_d_reg != want_lvl) begin
        f_start = 1'b1;
      end
    end
  end
  // Any level change while filtering throws the buffer away
  assign f_abort = !meas_en || (fbusy && latch_in != latch_d_reg);

  wlm_filter #(.CW(CW)) u_filt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(f_start),
    .abort(f_abort),
    .inc(enc_inc),
    .limit(filt_reg),
    .pos(pos),
    .busy(fbusy),
    .expired(fexp),
    .held(fheld)
  );

  assign rise_wr = state_reg == WLM_WAIT_EDGE && fexp && !low_first && !phase_reg;
  assign fall_wr = state_reg == WLM_WAIT_EDGE && fexp && (low_first || phase_reg);
  assign done_set = rise_wr && !both || fall_wr;
  assign conf_set = ctrl_reg[WLM_CTRL_MEAS_EN] && ctrl_reg[WLM_CTRL_CMP_EN];
  assign ev = {conf_set, done_set};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_d_reg <= 1'b0;
    end else begin
      latch_d_reg <= latch_in;
    end
  end

  // Measurement sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= WLM_IDLE;
      phase_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        WLM_IDLE: begin
          phase_reg <= 1'b0;
          if (meas_en && mode_ok) begin
            state_reg <= WLM_WAIT_EDGE;
            if (!both || !latch_in) begin
              phase_reg <= 1'b0;
            end else begin
              phase_reg <= 1'b1;
            end
          end
        end
        WLM_WAIT_EDGE: begin
          // A final capture already written still ends the run
          if (done_set) begin
            state_reg <= WLM_DONE;
          end else if (!meas_en || !mode_ok) begin
            state_reg <= WLM_IDLE;
          end else if (rise_wr) begin
            phase_reg <= 1'b1;
          end
        end
        WLM_DONE: begin
          if (!meas_en) begin
            state_reg <= WLM_IDLE;
          end
        end
        default: begin
          state_reg <= WLM_IDLE;
        end
      endcase
    end
  end

  // Capture registers change only on qualified expiry, rise_reg also on the initial capture from IDLE
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_reg <= '0;
      fall_reg <= '0;
    end else begin
      if (state_reg == WLM_IDLE && meas_en && mode_ok && both && latch_in) begin
        rise_reg <= pos;
      end else if (rise_wr) begin
        rise_reg <= fheld;
      end
      if (fall_wr) begin
        fall_reg <= fheld;
      end
    end
  end

  // Control and filter registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= WLM_CTRL_RST;
      filt_reg <= WLM_FILT_RST;
      mask_reg <= '0;
    end else if (wr) begin
      if (paddr == WLM_CTRL_OFS) ctrl_reg <= pwdata;
      if (paddr == WLM_FILT_OFS) filt_reg <= pwdata;
      if (paddr == WLM_MASK_OFS) mask_reg <= pwdata[WLM_STAT_W-1:0];
    end
  end

  // Sticky status; a new event beats a write-one clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= '0;
    end else begin
      for (int i = 0; i < WLM_STAT_W; i++) begin
        if (ev[i]) begin
          stat_reg[i] <= 1'b1;
        end else if (i == WLM_STAT_DONE && !meas_en) begin
          stat_reg[i] <= 1'b0;
        end else if (wr && paddr == WLM_STAT_OFS && pwdata[i]) begin
          stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_reg & mask_reg);
    end
  end

  // APB: one wait-free access phase, data prepared in setup
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !map_hit;
      if (rd) begin
        unique case (paddr)
          WLM_CTRL_OFS: prdata <= ctrl_reg;
          WLM_FILT_OFS: prdata <= filt_reg;
          WLM_RISE_OFS: prdata <= rise_reg;
          WLM_FALL_OFS: prdata <= fall_reg;
          WLM_STAT_OFS: prdata <= {{(32-WLM_STAT_W){1'b0}}, stat_reg};
          WLM_MASK_OFS: prdata <= {{(32-WLM_STAT_W){1'b0}}, mask_reg};
          WLM_CNT_OFS: prdata <= pos;
          default: prdata <= '0;
        endcase
      end
    end
  end

  // Increments seen by the running filter; the expiry check needs its own count
  logic [CW-1:0] seen_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_reg <= '0;
    end else if (f_start) begin
      seen_reg <= '0;
    end else if (fbusy && enc_inc) begin
      seen_reg <= seen_reg + 1'b1;
    end
  end

  // Each check ties one capture, status, state, filter, count or interrupt effect to its cause
  done_after_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rise_wr && !both) || fall_wr |=> stat_reg[WLM_STAT_DONE]) else $error("done not set");
  mode23_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rise_wr && mode[2:1] == 2'b01 |=> state_reg == WLM_DONE) else $error("mode 2/3 not ended");
  rise_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rise_wr |=> rise_reg == $past(fheld)) else $error("rising capture wrong");
  fall_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fall_wr |=> fall_reg == $past(fheld)) else $error("falling capture wrong");
  buffer_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    f_start |=> fheld == $past(pos)) else $error("edge value not buffered");
  discard_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    f_abort && fbusy |=> !fexp ##1 !fexp) else $error("aborted filter expired");
  hold_caps_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rise_wr && !fall_wr && state_reg != WLM_IDLE |=> $stable(fall_reg)) else $error("capture moved");
  hold_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rise_wr && state_reg != WLM_IDLE |=> $stable(rise_reg)) else $error("rising capture moved");
  low_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    low_first |-> !rise_wr) else $error("rising capture in low mode");
  count_dir_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    enc_inc && mode[0] && $stable(mode) |=> pos == $past(pos) - 1) else $error("direction wrong");
  count_up_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    enc_inc && !mode[0] |=> pos == $past(pos) + 1) else $error("up count wrong");
  disable_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !meas_en && !ev[WLM_STAT_DONE] |=> !stat_reg[WLM_STAT_DONE]) else $error("done not cleared");
  abort_disable_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !meas_en |=> !fbusy) else $error("filter kept running while disabled");
  start_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == WLM_WAIT_EDGE && meas_en && !fbusy && !low_first && !phase_reg && latch_in && !latch_d_reg
    |=> fbusy) else $error("high edge did not start filter");
  end_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == WLM_WAIT_EDGE && meas_en && !fbusy && phase_reg && !latch_in && latch_d_reg
    |=> fbusy) else $error("low edge did not start filter");
  init_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == WLM_IDLE && meas_en && mode_ok && both && latch_in |=> rise_reg == $past(pos))
    else $error("initial value not captured");
  filter_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fexp |-> seen_reg >= $past(filt_reg)) else $error("filter expired early");
  bad_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !mode_ok && !done_set && state_reg != WLM_DONE |=> state_reg == WLM_IDLE) else $error("reserved mode ran");
  conflict_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conf_set |=> stat_reg[WLM_STAT_CONFLICT]) else $error("conflict not flagged");
  irq_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> irq == $past(|(stat_reg & mask_reg))) else $error("interrupt level wrong");

  // Main scenarios to be seen at least once
  cov_done_c: cover property (@(posedge sys_clk) disable iff (!rst_n) state_reg == WLM_DONE);
  cov_rise_c: cover property (@(posedge sys_clk) disable iff (!rst_n) rise_wr);
  cov_fall_c: cover property (@(posedge sys_clk) disable iff (!rst_n) fall_wr);
  cov_abort_c: cover property (@(posedge sys_clk) disable iff (!rst_n) f_abort && fbusy && meas_en);
  cov_irq_c: cover property (@(posedge sys_clk) disable iff (!rst_n) irq);
endmodule

// ---- rtl/wlm_pkg.sv ----
// Package with register map, field positions and mode codes of the length measurement block
package wlm_pkg;
  localparam int WLM_AW = 8;
  localparam logic [7:0] WLM_CTRL_OFS = 8'h00;
  localparam logic [7:0] WLM_FILT_OFS = 8'h04;
  localparam logic [7:0] WLM_RISE_OFS = 8'h08;
  localparam logic [7:0] WLM_FALL_OFS = 8'h0C;
  localparam logic [7:0] WLM_STAT_OFS = 8'h10;
  localparam logic [7:0] WLM_MASK_OFS = 8'h14;
  localparam logic [7:0] WLM_CNT_OFS = 8'h18;
  localparam int WLM_CTRL_MEAS_EN = 0;
  localparam int WLM_CTRL_CMP_EN = 1;
  localparam int WLM_CTRL_MODE_LO = 4;
  localparam int WLM_MODE_W = 3;
  localparam int WLM_STAT_DONE = 0;
  localparam int WLM_STAT_CONFLICT = 1;
  localparam int WLM_STAT_W = 2;
  localparam logic [2:0] WLM_MODE_MAX = 3'h5;
  localparam logic [31:0] WLM_FILT_RST = 32'h0000_0000;
  localparam logic [31:0] WLM_CTRL_RST = 32'h0000_0000;
  typedef enum logic [3:0] {
    WLM_IDLE = 4'b0001,
    WLM_WAIT_EDGE = 4'b0010,
    WLM_FILTER = 4'b0100,
    WLM_DONE = 4'b1000
  } wlm_state_e;
endpackage

// ---- rtl/wlm_filter.sv ----
// Increment-counting edge filter with buffered counter value
`timescale 1ns/100ps
module wlm_filter import wlm_pkg::*; #(
  parameter int CW = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic inc,
  input wire logic [CW-1:0] limit,
  input wire logic [CW-1:0] pos,
  output logic busy,
  output logic expired,
  output logic [CW-1:0] held
);
  logic [CW-1:0] cnt_reg;
  if (CW < 1) begin
    $error("wlm_filter: width too small");
  end
  // Start buffers the position and restarts the count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt_reg <= '0;
      held <= '0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        busy <= 1'b1;
        cnt_reg <= '0;
        held <= pos;
      end else if (busy && cnt_reg >= limit) begin
        busy <= 1'b0;
        expired <= 1'b1;
      end else if (busy && inc) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule

// ---- rtl/wlm_counter.sv ----
// Position counter, direction taken from the measurement mode
`timescale 1ns/100ps
module wlm_counter import wlm_pkg::*; #(
  parameter int CW = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic inc,
  input wire logic down,
  output logic [CW-1:0] pos
);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= '0;
    end else if (inc) begin
      pos <= down ? pos - 1'b1 : pos + 1'b1;
    end
  end
endmodule

// ---- tb/wlm_sensor.sv ----
// Behavioural workpiece sensor and encoder feeding the latch input and increments
`timescale 1ns/100ps
module wlm_sensor (
  input wire logic sys_clk,
  output logic latch_in,
  output logic enc_inc
);
  initial begin
    latch_in = 1'b0;
    enc_inc = 1'b0;
  end
  task automatic set_level(input logic v);
    @(posedge sys_clk);
    latch_in <= v;
  endtask
  // One increment every two cycles so no pulse merges with the next
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      enc_inc <= 1'b1;
      @(posedge sys_clk);
      enc_inc <= 1'b0;
    end
  endtask
endmodule

// ---- tb/wlm_top_tb.sv ----
// Self-checking bench for the length measurement unit
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module wlm_top_tb import wlm_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic latch_in;
  logic enc_inc;
  logic irq;
  int error_cnt = 0;
  int comparisons = 0;
  integer seed = 13;
  int filt;
  logic [31:0] pos_exp, rise_exp, fall_exp, rd;
  logic er;

  always #5 sys_clk = ~sys_clk;

  wlm_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .latch_in(latch_in), .enc_inc(enc_inc),
    .irq(irq));
  wlm_sensor sensor (.sys_clk(sys_clk), .latch_in(latch_in), .enc_inc(enc_inc));

  function automatic logic [31:0] step(input logic [31:0] p, input int k, input logic dn);
    return dn ? p - 32'(k) : p + 32'(k);
  endfunction
  function automatic logic [31:0] ctrl_word(input int m, input logic en);
    return (32'(m) << WLM_CTRL_MODE_LO) | {31'h0, en};
  endfunction

  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // A slave that never answers is caught by the watchdog
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, x, r)
  endtask
  task automatic move(input int k, input logic dn);
    sensor.pulses(k);
    pos_exp = step(pos_exp, k, dn);
  endtask
  // Edge, then filter pulses that move the position past the value to be kept
  task automatic meas(input logic lv, input logic dn, output logic [31:0] v);
    v = pos_exp;
    sensor.set_level(lv);
    repeat (4) @(posedge sys_clk);
    move(filt, dn);
    repeat (6) @(posedge sys_clk);
  endtask

  initial begin
    repeat (50000) @(posedge sys_clk);
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    pos_exp = 32'h0;
    rise_exp = 32'h0;
    fall_exp = 32'h0;
    rdchk("filt_rst", WLM_FILT_OFS, WLM_FILT_RST);
    wr(WLM_FILT_OFS, 32'hFFFF_FFFF);
    rdchk("filt_full", WLM_FILT_OFS, 32'hFFFF_FFFF);
    apb(1'b0, 8'h1C, 32'h0, rd, er);
    `CHK("unmapped_err", 1'b1, er)
    `CHK("unmapped_dat", 32'h0, rd)
    wr(WLM_RISE_OFS, 32'h1234_5678);
    rdchk("rise_ro", WLM_RISE_OFS, 32'h0);
    wr(WLM_MASK_OFS, 32'h1);
    for (int m = 0; m < 6; m++) begin
      filt = $random(seed) & 3;
      wr(WLM_FILT_OFS, 32'(filt));
      sensor.set_level(m >= 4);
      wr(WLM_CTRL_OFS, ctrl_word(m, 1'b1));
      move(($random(seed) & 3) + 1, m[0]);
      if (m < 4) begin
        meas(1'b1, m[0], rise_exp);
        rdchk("rise_cap", WLM_RISE_OFS, rise_exp);
      end else begin
        meas(1'b0, m[0], fall_exp);
        rdchk("fall_start", WLM_FALL_OFS, fall_exp);
      end
      if (m < 2) begin
        rdchk("done_early", WLM_STAT_OFS, 32'h0);
        meas(1'b0, m[0], fall_exp);
        rdchk("fall_end", WLM_FALL_OFS, fall_exp);
      end
      rdchk("fall_keep", WLM_FALL_OFS, fall_exp);
      rdchk("pos", WLM_CNT_OFS, pos_exp);
      rdchk("done", WLM_STAT_OFS, 32'h1);
      `CHK("irq_on", 1'b1, irq)
      wr(WLM_MASK_OFS, 32'h0);
      repeat (2) @(posedge sys_clk);
      `CHK("irq_masked", 1'b0, irq)
      wr(WLM_MASK_OFS, 32'h1);
      if (m == 2) begin
        wr(WLM_STAT_OFS, 32'h1);
        rdchk("done_w1c", WLM_STAT_OFS, 32'h0);
        `CHK("irq_w1c", 1'b0, irq)
      end
      wr(WLM_CTRL_OFS, ctrl_word(m, 1'b0));
      rdchk("done_clr", WLM_STAT_OFS, 32'h0);
    end
    // Glitch shorter than the filter must leave the capture alone
    filt = 4;
    wr(WLM_FILT_OFS, 32'h4);
    sensor.set_level(1'b0);
    wr(WLM_CTRL_OFS, ctrl_word(2, 1'b1));
    sensor.set_level(1'b1);
    repeat (4) @(posedge sys_clk);
    move(2, 1'b0);
    sensor.set_level(1'b0);
    repeat (4) @(posedge sys_clk);
    move(3, 1'b0);
    rdchk("rise_hold", WLM_RISE_OFS, rise_exp);
    meas(1'b1, 1'b0, rise_exp);
    rdchk("rise_retry", WLM_RISE_OFS, rise_exp);
    rdchk("done_retry", WLM_STAT_OFS, 32'h1);
    wr(WLM_CTRL_OFS, 32'h0);
    wr(WLM_CTRL_OFS, ctrl_word(0, 1'b1));
    repeat (4) @(posedge sys_clk);
    rise_exp = pos_exp;
    rdchk("rise_init", WLM_RISE_OFS, rise_exp);
    meas(1'b0, 1'b0, fall_exp);
    rdchk("fall_buf", WLM_FALL_OFS, fall_exp);
    wr(WLM_CTRL_OFS, 32'h0);
    sensor.set_level(1'b0);
    wr(WLM_CTRL_OFS, 32'h3);
    meas(1'b1, 1'b0, rd);
    rdchk("conflict", WLM_STAT_OFS, 32'h2);
    rdchk("conf_rise", WLM_RISE_OFS, rise_exp);
    wr(WLM_CTRL_OFS, 32'h0);
    wr(WLM_STAT_OFS, 32'h2);
    rdchk("conf_clr", WLM_STAT_OFS, 32'h0);
    // Reserved mode must never capture
    sensor.set_level(1'b0);
    wr(WLM_CTRL_OFS, ctrl_word(6, 1'b1));
    meas(1'b1, 1'b0, rd);
    rdchk("bad_mode", WLM_STAT_OFS, 32'h0);
    rdchk("bad_rise", WLM_RISE_OFS, rise_exp);
    rdchk("pos_end", WLM_CNT_OFS, pos_exp);
    final_report();
  end
endmodule
